// >>> verilog/adc_ctrl_regs.svh
// Register map, field positions, reset values and codes of the ADC control.
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

`define ADDR_CONTROL      32'hFFFF0500
`define ADDR_POS_SELECT   32'hFFFF0504
`define ADDR_NEG_SELECT   32'hFFFF0508
`define ADDR_BLOCK_STATUS 32'hFFFF0540

`define RESET_CONTROL     16'h0600
`define RESET_POS_SELECT  8'h00
`define RESET_NEG_SELECT  8'h01

`define CONTROL_WMASK     16'h1FBF
`define SELECT_WMASK      8'h1F

`define DIV_MSB           12
`define DIV_LSB           10
`define ACQ_MSB           9
`define ACQ_LSB           8
`define START_EN_BIT      7
`define POWER_BIT         5
`define MODE_MSB          4
`define MODE_LSB          3
`define TRIG_MSB          2
`define TRIG_LSB          0

`define DIV_MAX           3'h5
`define ACQ_MAX           2'h3
`define MODE_RESERVED     2'h3

`define TRIG_PIN          3'h0
`define TRIG_TIMER1       3'h1
`define TRIG_TIMER0       3'h2
`define TRIG_SW_SINGLE    3'h3
`define TRIG_SW_CONT      3'h4
`define TRIG_LOGIC_ARRAY  3'h5

`define CHAN_TEMP_SENSOR  5'h10

`endif

// >>> verilog/adc_ctrl_pkg.sv
// Types shared by the ADC control logic.
package adc_ctrl_pkg;

    typedef enum logic [0:0] {
        CONV_IDLE,
        CONV_BUSY
    } conv_state_e;

endpackage

// >>> verilog/sync2.sv
// Two-stage synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
module sync2 (
    // Clock and reset.
    input  wire logic clock,
    input  wire logic nrst,
    // Level in and out.
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_q;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            meta_q   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// >>> verilog/conv_clock_divider.sv
// Divider that makes the converter clock as a one-cycle enable pulse.
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module conv_clock_divider #(
    parameter int CNT_W = 5
) (
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       nrst,
    // Divide code, ratio is two to the power of the code.
    input  wire logic [2:0] div_sel,
    // Enable pulse at the divided rate.
    output logic            clk_en
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] last;

    assign last = CNT_W'((1 << div_sel) - 1);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cnt_q  <= '0;
            clk_en <= 1'b0;
        end else if (cnt_q >= last) begin
            cnt_q  <= '0;
            clk_en <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 1'b1;
            clk_en <= 1'b0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    div_gap_a: assert property (
        clk_en && div_sel != 3'h0 && $stable(div_sel) |=> !clk_en)
        else $error("Divided enable came on two cycles in a row.");

endmodule

// >>> verilog/adc_control_registers.sv
// Register front end and conversion trigger control of the ADC.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"

// Behaviour
// - Bits 12:10 divide the converter clock and bits 9:8 set acquisition.
// - A conversion may start only while start-enable bit 7 is set, except a restart of a running continuous sequence.
// - Clearing start-enable blocks new starts but not continuous conversion.
// - Power bit 5 set runs the converter, clear holds it powered down.
// - Bits 4:3 select the input mode, with code 11 reserved.
// - Bits 2:0 pick pin, timer 1, timer 0, continuous or array triggers.
// - Code 011 runs one conversion, then hardware rewrites the field to 000.
// - Positive select picks channel 0 to 15 or one of four internal nodes.
// - The 8-bit negative select resets to 0x01.
// - Negative select routes channels 0 to 15 or the internal reference.
// - The temperature channel forces acquisition 16 and divide by 32.
module adc_control_registers
    import adc_ctrl_pkg::*;
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        nrst,
    // Register port.
    input  wire logic [31:0] addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // Trigger sources.
    input  wire logic        external_trigger_pin,
    input  wire logic        timer1_trigger,
    input  wire logic        timer0_trigger,
    input  wire logic        logic_array_trigger,
    // Converter side.
    input  wire logic        conv_done,
    output logic             conv_start,
    output logic             converter_power,
    output logic      [1:0]  input_mode,
    output logic      [4:0]  pos_channel,
    output logic      [4:0]  neg_channel,
    output logic      [2:0]  div_sel,
    output logic      [1:0]  acq_sel,
    output logic             converter_base_clock
);

    logic [15:0] ctrl_q;
    logic [7:0]  pos_q;
    logic [7:0]  neg_q;
    conv_state_e state_q;
    logic        cont_q;
    logic        single_q;
    logic        pin_sync;
    logic        pin_q;
    logic        tmr1_q;
    logic        tmr0_q;
    logic        pla_q;
    logic        trig_edge;
    logic        start_d;
    logic        cont_go;
    logic        mode_ok;
    logic [2:0]  trig;
    logic        wr_ctrl;
    logic        done_single;

    assign trig        = ctrl_q[`TRIG_MSB:`TRIG_LSB];
    assign wr_ctrl     = wr && addr == `ADDR_CONTROL;
    assign done_single = conv_done && state_q == CONV_BUSY && single_q;

    sync2 pin_sync_u (
        .clock    (clock),
        .nrst     (nrst),
        .async_in (external_trigger_pin),
        .sync_out (pin_sync)
    );

    // Edges are kept so that a held trigger level starts only once.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pin_q  <= 1'b0;
            tmr1_q <= 1'b0;
            tmr0_q <= 1'b0;
            pla_q  <= 1'b0;
        end else begin
            pin_q  <= pin_sync;
            tmr1_q <= timer1_trigger;
            tmr0_q <= timer0_trigger;
            pla_q  <= logic_array_trigger;
        end
    end

    always_comb begin
        case (trig)
            `TRIG_PIN:         trig_edge = pin_sync && !pin_q;
            `TRIG_TIMER1:      trig_edge = timer1_trigger && !tmr1_q;
            `TRIG_TIMER0:      trig_edge = timer0_trigger && !tmr0_q;
            `TRIG_SW_SINGLE:   trig_edge = !single_q;
            `TRIG_SW_CONT:     trig_edge = 1'b1;
            `TRIG_LOGIC_ARRAY: trig_edge = logic_array_trigger && !pla_q;
            default:           trig_edge = 1'b0;
        endcase
    end

    assign mode_ok = ctrl_q[`MODE_MSB:`MODE_LSB] != `MODE_RESERVED;
    // A running continuous sequence restarts without start-enable.
    assign cont_go = cont_q && trig == `TRIG_SW_CONT;
    assign start_d = state_q == CONV_IDLE && ctrl_q[`POWER_BIT] && mode_ok
                     && ((ctrl_q[`START_EN_BIT] && trig_edge)
                         || cont_go);

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state_q    <= CONV_IDLE;
            conv_start <= 1'b0;
        end else begin
            conv_start <= start_d;
            case (state_q)
                CONV_IDLE: if (start_d) begin
                    state_q <= CONV_BUSY;
                end
                CONV_BUSY: if (conv_done || !ctrl_q[`POWER_BIT]) begin
                    state_q <= CONV_IDLE;
                end
                default: state_q <= CONV_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cont_q <= 1'b0;
        end else if (trig != `TRIG_SW_CONT || !ctrl_q[`POWER_BIT]
                     || !mode_ok) begin
            cont_q <= 1'b0;
        end else if (start_d) begin
            cont_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            single_q <= 1'b0;
        end else if (start_d && trig == `TRIG_SW_SINGLE) begin
            single_q <= 1'b1;
        end else if (done_single || state_q == CONV_IDLE) begin
            single_q <= 1'b0;
        end
    end

    // The hardware revert of the trigger field wins over a software write
    // in the same cycle, so the completed single conversion is never lost.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctrl_q <= `RESET_CONTROL;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= wdata & `CONTROL_WMASK;
            end
            if (done_single) begin
                ctrl_q[`TRIG_MSB:`TRIG_LSB] <= `TRIG_PIN;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pos_q <= `RESET_POS_SELECT;
            neg_q <= `RESET_NEG_SELECT;
        end else if (wr && addr == `ADDR_POS_SELECT) begin
            pos_q <= wdata[7:0] & `SELECT_WMASK;
        end else if (wr && addr == `ADDR_NEG_SELECT) begin
            neg_q <= wdata[7:0] & `SELECT_WMASK;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                `ADDR_CONTROL:      rdata <= ctrl_q;
                `ADDR_POS_SELECT:   rdata <= {8'h00, pos_q};
                `ADDR_NEG_SELECT:   rdata <= {8'h00, neg_q};
                `ADDR_BLOCK_STATUS: rdata <= {13'h0, single_q, cont_q,
                                              state_q == CONV_BUSY};
                default:            rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    // Settings go out registered; temperature readings override the timing.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            converter_power <= 1'b0;
            input_mode      <= 2'h0;
            pos_channel     <= 5'h00;
            neg_channel     <= 5'h01;
            div_sel         <= 3'h1;
            acq_sel         <= 2'h2;
        end else begin
            converter_power <= ctrl_q[`POWER_BIT];
            input_mode      <= ctrl_q[`MODE_MSB:`MODE_LSB];
            pos_channel     <= pos_q[4:0];
            neg_channel     <= neg_q[4:0];
            if (pos_q[4:0] == `CHAN_TEMP_SENSOR) begin
                div_sel <= `DIV_MAX;
                acq_sel <= `ACQ_MAX;
            end else begin
                // Reserved divide codes are clamped to the slowest rate.
                if (ctrl_q[`DIV_MSB:`DIV_LSB] > `DIV_MAX) begin
                    div_sel <= `DIV_MAX;
                end else begin
                    div_sel <= ctrl_q[`DIV_MSB:`DIV_LSB];
                end
                acq_sel <= ctrl_q[`ACQ_MSB:`ACQ_LSB];
            end
        end
    end

    conv_clock_divider #(
        .CNT_W (5)
    ) divider_u (
        .clock   (clock),
        .nrst    (nrst),
        .div_sel (div_sel),
        .clk_en  (converter_base_clock)
    );

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    start_enable_a: assert property (
        conv_start && !$past(cont_q) |-> $past(ctrl_q[`START_EN_BIT]))
        else $error("Conversion started with start-enable clear.");

    cont_keeps_a: assert property (
        cont_q && trig == `TRIG_SW_CONT && mode_ok && ctrl_q[`POWER_BIT]
        && state_q == CONV_IDLE && !ctrl_q[`START_EN_BIT] |=> conv_start)
        else $error("Continuous sequence stopped by start-enable.");

    power_down_a: assert property (
        !ctrl_q[`POWER_BIT] |=> !conv_start && !converter_power)
        else $error("Converter started or powered while power bit clear.");

    mode_reserved_a: assert property (
        ctrl_q[`MODE_MSB:`MODE_LSB] == `MODE_RESERVED |=> !conv_start)
        else $error("Conversion started in reserved input mode.");

    trig_reserved_a: assert property (
        trig > `TRIG_LOGIC_ARRAY |=> !conv_start)
        else $error("Conversion started on reserved trigger code.");

    single_revert_a: assert property (
        done_single |=> trig == `TRIG_PIN && !single_q)
        else $error("Single conversion did not revert the trigger.");

    temp_force_a: assert property (
        pos_q[4:0] == `CHAN_TEMP_SENSOR |=> div_sel == `DIV_MAX
        && acq_sel == `ACQ_MAX)
        else $error("Temperature channel timing not forced.");

    reserved_zero_a: assert property (
        rd && addr == `ADDR_CONTROL |=> rdata[15:13] == 3'h0 && !rdata[6])
        else $error("Reserved control bits read nonzero.");

    reset_value_a: assert property (
        @(posedge clock) disable iff (1'b0)
        !nrst |=> ctrl_q == `RESET_CONTROL && pos_q == `RESET_POS_SELECT
        && neg_q == `RESET_NEG_SELECT)
        else $error("Registers not at reset values after reset.");

    // A start always enters busy, so two starts can never touch.
    start_pulse_a: assert property (
        conv_start |=> !conv_start)
        else $error("Conversion start lasted more than one cycle.");

    busy_no_start_a: assert property (
        state_q == CONV_BUSY |=> !conv_start)
        else $error("Conversion started while one was running.");

    power_follow_a: assert property (
        converter_power == $past(ctrl_q[`POWER_BIT]))
        else $error("Power output does not follow the power bit.");

    mode_follow_a: assert property (
        input_mode == $past(ctrl_q[`MODE_MSB:`MODE_LSB]))
        else $error("Input mode output does not follow the control.");

    select_route_a: assert property (
        pos_channel == $past(pos_q[4:0])
        && neg_channel == $past(neg_q[4:0]))
        else $error("Channel outputs do not follow the selects.");

    cont_run_c: cover property (cont_q && conv_start ##1 !ctrl_q[7]);
    single_done_c: cover property (done_single);
    cont_hold_c: cover property (
        cont_q && !ctrl_q[`START_EN_BIT] ##1 conv_start);
    temp_conv_c: cover property (
        conv_start && pos_q[4:0] == `CHAN_TEMP_SENSOR);

endmodule

// >>> verification/test_adc_control_registers.sv
// Self-checking bench for the ADC control register front end.
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module test_adc_control_registers;
    typedef struct packed {
        logic [31:0] a;
        logic [15:0] d;
        logic [15:0] r;
    } reg_row_s;
    typedef struct packed {
        logic [15:0] c;
        logic [3:0]  m;
        logic [1:0]  n;
    } trig_row_s;

    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic [31:0] addr = 32'h0;
    logic [15:0] wdata = 16'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        external_trigger_pin = 1'b0;
    logic        timer1_trigger = 1'b0;
    logic        timer0_trigger = 1'b0;
    logic        logic_array_trigger = 1'b0;
    logic        conv_done = 1'b0;
    logic        conv_start;
    logic        converter_power;
    logic [1:0]  input_mode;
    logic [4:0]  pos_channel;
    logic [4:0]  neg_channel;
    logic [2:0]  div_sel;
    logic [1:0]  acq_sel;
    logic        converter_base_clock;
    int          failures = 0;
    int          n_checks = 0;
    int          n_starts = 0;
    int          n;
    int          s;

    // Unmapped rows write zero, so an aliased decode would wipe control.
    reg_row_s regs[4] = '{
        '{`ADDR_CONTROL, 16'hFFFF, 16'h1FBF},
        '{`ADDR_POS_SELECT, 16'hFFF3, 16'h0013},
        '{`ADDR_NEG_SELECT, 16'h00F0, 16'h0010},
        '{32'hFFFF0501, 16'h0000, 16'h0000}};
    // Trigger mask order is logic array, timer 0, timer 1, pin.
    trig_row_s trg[10] = '{
        '{16'h06A0, 4'h1, 2'h1}, '{16'h06A0, 4'hE, 2'h0},
        '{16'h06A1, 4'h2, 2'h1}, '{16'h06A2, 4'h4, 2'h1},
        '{16'h06A5, 4'h8, 2'h1}, '{16'h0621, 4'h2, 2'h0},
        '{16'h06B9, 4'h2, 2'h0}, '{16'h0681, 4'h2, 2'h0},
        '{16'h06A6, 4'hF, 2'h0}, '{16'h06A7, 4'hF, 2'h0}};

    adc_control_registers i_dut (
        .clock                (clock),
        .nrst                 (nrst),
        .addr                 (addr),
        .wdata                (wdata),
        .wr                   (wr),
        .rd                   (rd),
        .rdata                (rdata),
        .external_trigger_pin (external_trigger_pin),
        .timer1_trigger       (timer1_trigger),
        .timer0_trigger       (timer0_trigger),
        .logic_array_trigger  (logic_array_trigger),
        .conv_done            (conv_done),
        .conv_start           (conv_start),
        .converter_power      (converter_power),
        .input_mode           (input_mode),
        .pos_channel          (pos_channel),
        .neg_channel          (neg_channel),
        .div_sel              (div_sel),
        .acq_sel              (acq_sel),
        .converter_base_clock (converter_base_clock)
    );

    always #12.5 clock = ~clock;

    // The converter stand-in finishes one cycle after every start.
    always @(posedge clock) begin
        conv_done <= conv_start;
        if (conv_start === 1'b1) begin
            n_starts <= n_starts + 1;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [15:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        chk(rdata, exp);
        @(negedge clock);
        chk(rdata, 16'h0000);
    endtask

    // Measured twice, since a divide change may cut the running count short.
    task automatic period(output int p);
        repeat (2) begin
            p = 0;
            while (converter_base_clock !== 1'b1 && p < 100) begin
                @(negedge clock);
                p++;
            end
            p = 0;
            do begin
                @(negedge clock);
                p++;
            end while (converter_base_clock !== 1'b1 && p < 100);
        end
    endtask

    task automatic fire(input trig_row_s t);
        int b;
        wr_reg(`ADDR_CONTROL, t.c);
        b = n_starts;
        {logic_array_trigger, timer0_trigger, timer1_trigger,
         external_trigger_pin} <= t.m;
        repeat (4) @(posedge clock);
        {logic_array_trigger, timer0_trigger, timer1_trigger,
         external_trigger_pin} <= 4'h0;
        repeat (10) @(posedge clock);
        chk(16'(n_starts - b), {14'h0, t.n});
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #400000;
        failures++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        rd_chk(`ADDR_CONTROL, 16'h0600);
        rd_chk(`ADDR_POS_SELECT, 16'h0000);
        rd_chk(`ADDR_NEG_SELECT, 16'h0001);
        chk({8'h0, converter_power, input_mode, div_sel, acq_sel},
            16'h0006);
        foreach (regs[i]) begin
            wr_reg(regs[i].a, regs[i].d);
            rd_chk(regs[i].a, regs[i].r);
        end
        rd_chk(`ADDR_CONTROL, 16'h1FBF);
        chk({13'h0, div_sel}, 16'h0005);
        chk({6'h0, pos_channel, neg_channel}, 16'h0270);
        wr_reg(`ADDR_POS_SELECT, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            wr_reg(`ADDR_CONTROL, {3'h0, i[2:0], i[1:0], 3'b001,
                                   i[0] ? 2'b01 : 2'b10, 3'h0});
            period(n);
            chk({8'h0, converter_power, input_mode, div_sel, acq_sel},
                {9'h1, i[0] ? 2'b01 : 2'b10, i[2:0], i[1:0]});
            chk(n[15:0], 16'(1 << i));
        end
        wr_reg(`ADDR_CONTROL, 16'h0620);
        wr_reg(`ADDR_POS_SELECT, 16'h0010);
        period(n);
        chk({11'h0, div_sel, acq_sel}, 16'h0017);
        chk(n[15:0], 16'h0020);
        wr_reg(`ADDR_POS_SELECT, 16'h0001);
        chk({11'h0, div_sel, acq_sel}, 16'h0006);
        repeat (200) @(posedge clock);
        foreach (trg[i]) begin
            fire(trg[i]);
        end
        s = n_starts;
        wr_reg(`ADDR_CONTROL, 16'h06A3);
        repeat (10) @(posedge clock);
        chk(16'(n_starts - s), 16'h0001);
        rd_chk(`ADDR_CONTROL, 16'h06A0);
        fire(trig_row_s'{16'h0620, 4'h1, 2'h0});
        s = n_starts;
        wr_reg(`ADDR_CONTROL, 16'h06A4);
        repeat (20) @(posedge clock);
        chk({15'h0, (n_starts - s) > 2}, 16'h0001);
        wr_reg(`ADDR_CONTROL, 16'h0624);
        s = n_starts;
        repeat (20) @(posedge clock);
        chk({15'h0, (n_starts - s) > 2}, 16'h0001);
        wr_reg(`ADDR_CONTROL, 16'h0604);
        repeat (3) @(posedge clock);
        s = n_starts;
        repeat (20) @(posedge clock);
        chk(16'(n_starts - s), 16'h0000);
        rd_chk(`ADDR_BLOCK_STATUS, 16'h0000);
        wr_reg(`ADDR_CONTROL, 16'h1234);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        rd_chk(`ADDR_CONTROL, 16'h0600);
        chk({8'h0, converter_power, input_mode, div_sel, acq_sel},
            16'h0006);
        complete_run();
    end
endmodule
